//--- rtl/edg_guard.sv
/*
 * data eeprom guard: register slave, unlock sequence, write timing,
 * power-up window and configuration word decode.
 * assumes cpu strobes synchronous to mclk; the power-on reset is por,
 * rst is any other reset (external or watchdog).
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module edg_guard #(
    parameter int HOLD_CYCLES = edg_pkg::HOLD_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic por,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic prog_mode,
    input wire logic [13:0] prog_addr,
    input wire logic [13:0] prog_wdata,
    input wire logic prog_we,
    output logic [13:0] prog_rdata,
    output logic program_protect_field,
    output logic data_protect_bit,
    output logic watchdog_enable_cfg,
    output logic osc_select_hi,
    output logic osc_select_lo,
    output logic powerup_hold,
    output logic write_busy
);
    typedef enum logic [1:0] {
        K_IDLE = 2'b00,
        K_GOT55 = 2'b01,
        K_ARMED = 2'b10
    } edg_key_t;

    logic [7:0] data_q;
    logic [7:0] eaddr_q;
    logic write_permit_latch_q;
    logic write_aborted_flag_q;
    logic write_complete_flag_q;
    logic wr_q;
    logic rd_q;
    edg_key_t key_q;
    logic [13:0] cfg_q;
    logic [31:0] hold_cnt_q;
    logic [15:0] wcnt_q;
    logic [7:0] mem_rdata;
    logic mem_we;
    logic rd_pend_q;
    logic ctl_wr;
    logic start_ok;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ******************************
    // configuration word
    // ******************************
    // word at 2007h
    always_ff @(posedge mclk) begin
        if (por) begin
            cfg_q <= edg_pkg::CFG_RESET;
        end else if (prog_mode && prog_we && prog_addr == edg_pkg::CFG_ADDR) begin
            cfg_q <= prog_wdata;
        end
    end
    always_ff @(posedge mclk) begin
        if (por) begin
            prog_rdata <= 14'h0000;
        end else if (prog_mode && prog_addr == edg_pkg::CFG_ADDR) begin
            prog_rdata <= cfg_q;
        end else begin
            prog_rdata <= 14'h0000;
        end
    end
    assign program_protect_field = ~(&{cfg_q[13:8], cfg_q[6:4]});
    assign data_protect_bit = ~cfg_q[edg_pkg::CFG_DATA_PROT];
    assign watchdog_enable_cfg = cfg_q[edg_pkg::CFG_WDOG_EN];
    assign osc_select_hi = cfg_q[edg_pkg::CFG_FOSC_HI];
    assign osc_select_lo = cfg_q[edg_pkg::CFG_FOSC_LO];

    // ******************************
    // power-up timer
    // ******************************
    // power-on only
    // bit 3 disables
    // counter stops at its end, so only por can raise the hold again
    always_ff @(posedge mclk) begin
        if (por) begin
            hold_cnt_q <= 32'h00000000;
        end else if (!cfg_q[edg_pkg::CFG_HOLD_OFF] && hold_cnt_q != HOLD_CYCLES[31:0]) begin
            hold_cnt_q <= hold_cnt_q + 32'h00000001;
        end
    end
    assign powerup_hold = por || (!cfg_q[edg_pkg::CFG_HOLD_OFF]
                                  && hold_cnt_q != HOLD_CYCLES[31:0]);

    // ******************************
    // register slave
    // ******************************
    assign ctl_wr = wr_stb && hit(addr, edg_pkg::OFS_CTRL);
    assign start_ok = ctl_wr && wdata[edg_pkg::BIT_WR] && write_permit_latch_q
                      && key_q == K_ARMED && !powerup_hold && !wr_q;

    // unlock tracking
    // any other access breaks the sequence
    always_ff @(posedge mclk) begin
        if (rst || por) begin
            key_q <= K_IDLE;
        end else if (wr_stb) begin
            case (key_q)
                K_IDLE: key_q <= (hit(addr, edg_pkg::OFS_KEY) && wdata == edg_pkg::KEY_FIRST)
                                 ? K_GOT55 : K_IDLE;
                K_GOT55: key_q <= (hit(addr, edg_pkg::OFS_KEY) && wdata == edg_pkg::KEY_SECOND)
                                  ? K_ARMED : K_IDLE;
                default: key_q <= K_IDLE;
            endcase
        end else if (rd_stb) begin
            key_q <= K_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (por) begin
            write_permit_latch_q <= 1'b0;
        end else if (rst) begin
            write_permit_latch_q <= 1'b0;
        end else if (ctl_wr) begin
            write_permit_latch_q <= wdata[edg_pkg::BIT_PERMIT];
        end
    end

    // hardware clears start
    // limitation: data_q is written at the last count, keep it still
    always_ff @(posedge mclk) begin
        if (rst || por) begin
            wr_q <= 1'b0;
            wcnt_q <= 16'h0000;
        end else if (start_ok) begin
            wr_q <= 1'b1;
            wcnt_q <= 16'h0000;
        end else if (wr_q) begin
            if (wcnt_q == 16'(edg_pkg::WRITE_CYC - 1)) begin
                wr_q <= 1'b0;
            end
            wcnt_q <= wcnt_q + 16'h0001;
        end
    end
    assign write_busy = wr_q;
    assign mem_we = wr_q && wcnt_q == 16'(edg_pkg::WRITE_CYC - 1);

    always_ff @(posedge mclk) begin
        if (por) begin
            write_complete_flag_q <= 1'b0;
        end else if (rst) begin
            write_complete_flag_q <= 1'b0;
        end else if (mem_we) begin
            write_complete_flag_q <= 1'b1;
        end else if (ctl_wr && !wdata[edg_pkg::BIT_DONE]) begin
            write_complete_flag_q <= 1'b0;
        end
    end

    // abort flag kept
    // a later reset must not hide an earlier abort
    always_ff @(posedge mclk) begin
        if (por) begin
            write_aborted_flag_q <= 1'b0;
        end else if (rst) begin
            write_aborted_flag_q <= write_aborted_flag_q || wr_q;
        end else if (mem_we) begin
            write_aborted_flag_q <= 1'b0;
        end else if (ctl_wr) begin
            write_aborted_flag_q <= wdata[edg_pkg::BIT_ABORT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || por) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= ctl_wr && wdata[edg_pkg::BIT_RD] && !wr_q;
        end
    end
    always_ff @(posedge mclk) begin
        rd_pend_q <= rd_q;
    end

    always_ff @(posedge mclk) begin
        if (wr_stb && hit(addr, edg_pkg::OFS_DATA)) begin
            data_q <= wdata;
        end else if (rd_pend_q) begin
            data_q <= mem_rdata;
        end
        if (wr_stb && hit(addr, edg_pkg::OFS_ADDR) && !wr_q) begin
            eaddr_q <= wdata;
        end
    end

    edg_mem u_mem (
        .mclk(mclk),
        .we(mem_we),
        .addr(eaddr_q[5:0]),
        .wdata(data_q),
        .rdata(mem_rdata)
    );

    always_ff @(posedge mclk) begin
        if (rst || por) begin
            rdata <= 8'h00;
        end else if (!rd_stb) begin
            rdata <= 8'h00;
        end else if (hit(addr, edg_pkg::OFS_DATA)) begin
            rdata <= data_q;
        end else if (hit(addr, edg_pkg::OFS_ADDR)) begin
            rdata <= eaddr_q;
        end else if (hit(addr, edg_pkg::OFS_CTRL)) begin
            rdata <= {3'b000, write_complete_flag_q, write_aborted_flag_q,
                      write_permit_latch_q, wr_q, rd_q};
        end else if (hit(addr, edg_pkg::OFS_CFG)) begin
            rdata <= {data_protect_bit, program_protect_field, powerup_hold,
                      watchdog_enable_cfg, cfg_q[edg_pkg::CFG_HOLD_OFF], wr_q,
                      osc_select_hi, osc_select_lo};
        end else begin
            rdata <= 8'h00;
        end
    end

    // ******************************
    // checks
    // ******************************
    permit_por_a: assert property (@(posedge mclk) por |=> !write_permit_latch_q)
        else $error("permit not cleared at power-on");
    window_block_a: assert property (@(posedge mclk) disable iff (rst)
        powerup_hold && ctl_wr |=> !$rose(wr_q))
        else $error("write started in power-up window");
    unlock_need_a: assert property (@(posedge mclk) disable iff (rst || por)
        $rose(wr_q) |-> $past(key_q) == K_ARMED && $past(write_permit_latch_q))
        else $error("write started without unlock");
    done_set_a: assert property (@(posedge mclk) disable iff (rst || por)
        mem_we |=> write_complete_flag_q && !wr_q)
        else $error("completion not flagged");
    ctrl_upper_a: assert property (@(posedge mclk) disable iff (rst || por)
        $past(rd_stb) && $past(addr) == edg_pkg::OFS_CTRL |-> rdata[7:5] == 3'b000)
        else $error("control upper bits nonzero");
    key_read_a: assert property (@(posedge mclk) disable iff (rst || por)
        rd_stb && addr == edg_pkg::OFS_KEY |=> rdata == 8'h00)
        else $error("unlock register read nonzero");
    abort_keep_a: assert property (@(posedge mclk) disable iff (por)
        rst && wr_q |=> write_aborted_flag_q)
        else $error("interrupted write not flagged");
    wdt_cfg_a: assert property (@(posedge mclk) disable iff (por)
        !prog_mode |=> $stable(watchdog_enable_cfg))
        else $error("watchdog enable changed outside programming");
    cfg_prog_a: assert property (@(posedge mclk) disable iff (por)
        !prog_mode |=> $stable(cfg_q))
        else $error("config changed outside programming");
    wr_hold_a: assert property (@(posedge mclk) disable iff (rst || por)
        wr_q && !mem_we |=> wr_q)
        else $error("write start dropped before completion");
    key_break_a: assert property (@(posedge mclk) disable iff (rst || por)
        rd_stb && !wr_stb |=> key_q == K_IDLE)
        else $error("read left unlock sequence armed");
    timer_keep_a: assert property (@(posedge mclk) disable iff (por)
        rst && hold_cnt_q == HOLD_CYCLES[31:0] |=> !powerup_hold)
        else $error("power-up hold returned after reset");
    hold_off_a: assert property (@(posedge mclk) disable iff (por)
        cfg_q[edg_pkg::CFG_HOLD_OFF] |-> !powerup_hold)
        else $error("power-up hold while timer disabled");
endmodule : edg_guard
`default_nettype wire

//--- rtl/edg_pkg.sv
/*
 * constants for the data eeprom guard: register offsets, control field
 * positions, configuration word layout, unlock keys and timing counts.
 * assumes a single 250 mhz clock; nothing else.
 */
package edg_pkg;
    // ******************************
    // register offsets
    // ******************************
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_ADDR = 8'h09;
    localparam logic [7:0] OFS_CTRL = 8'h88;
    localparam logic [7:0] OFS_KEY = 8'h89;
    localparam logic [7:0] OFS_CFG = 8'h8a;
    // ******************************
    // control fields
    // ******************************
    localparam int BIT_RD = 0;
    localparam int BIT_WR = 1;
    localparam int BIT_PERMIT = 2;
    localparam int BIT_ABORT = 3;
    localparam int BIT_DONE = 4;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // ******************************
    // configuration word
    // ******************************
    localparam logic [13:0] CFG_ADDR = 14'h2007;
    localparam logic [13:0] CFG_SPACE_LO = 14'h2000;
    localparam logic [13:0] CFG_RESET = 14'h3fff;
    localparam int CFG_HOLD_OFF = 3;
    localparam int CFG_WDOG_EN = 2;
    localparam int CFG_DATA_PROT = 7;
    localparam int CFG_FOSC_HI = 1;
    localparam int CFG_FOSC_LO = 0;
    // ******************************
    // timing
    // ******************************
    localparam int CLK_MHZ = 250;
    localparam int HOLD_MS = 72;
    localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
    localparam int WRITE_US = 10;
    localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
endpackage : edg_pkg

//--- rtl/edg_mem.sv
/*
 * 64-byte data array with registered read port.
 * assumes one write or one read per cycle from the guard.
 */
`timescale 1ns/100ps
`default_nettype none
module edg_mem (
    input wire logic mclk,
    input wire logic we,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem_q [0:63];
    always_ff @(posedge mclk) begin
        if (we) begin
            mem_q[addr] <= wdata;
        end
        rdata <= mem_q[addr];
    end
endmodule : edg_mem
`default_nettype wire

//--- dv/edg_cpu.sv
/*
 * cpu side model: drives the register strobes of the data eeprom guard.
 * assumes each task is entered right after a rising mclk edge.
 */
`timescale 1ns/100ps
`default_nettype none
module edg_cpu (
    input wire logic mclk,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr_stb,
    output logic rd_stb
);
    // ****************
    // bus tasks
    // ****************
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end
    // strobe left high so back to back writes never assign twice per step
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge mclk);
    endtask : put
    task automatic idle();
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        @(posedge mclk);
    endtask : idle
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        d = rdata;
        @(posedge mclk);
    endtask : get
    task automatic unlock();
        put(edg_pkg::OFS_KEY, edg_pkg::KEY_FIRST);
        put(edg_pkg::OFS_KEY, edg_pkg::KEY_SECOND);
        put(edg_pkg::OFS_CTRL, 8'h06);
        idle();
    endtask : unlock
endmodule : edg_cpu
`default_nettype wire

//--- dv/tb_data_eeprom_guard_and_config_word.sv
/*
 * self-checking bench for the data eeprom guard.
 * assumes the guard's write time of 2500 cycles and a short power-up count.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_data_eeprom_guard_and_config_word;
    // ****************
    // harness
    // ****************
    localparam int HOLD_N = 40;
    logic mclk = 1'b0;
    logic rst = 1'b0;
    logic por = 1'b1;
    logic prog_mode = 1'b0;
    logic [13:0] prog_addr = 14'h0000;
    logic [13:0] prog_wdata = 14'h0000;
    logic prog_we = 1'b0;
    logic [13:0] prog_rdata;
    logic [7:0] addr, wdata, rdata, v;
    logic wr_stb, rd_stb, pp, dprot, wd, oh, ol, hold, busy;
    int fails = 0;
    int tests_run = 0;
    int n;
    always #2 mclk = ~mclk;
    edg_cpu i_cpu (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb));
    edg_guard #(.HOLD_CYCLES(HOLD_N)) i_dut (.mclk(mclk), .rst(rst), .por(por),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .prog_mode(prog_mode), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
        .prog_we(prog_we), .prog_rdata(prog_rdata), .program_protect_field(pp),
        .data_protect_bit(dprot), .watchdog_enable_cfg(wd), .osc_select_hi(oh),
        .osc_select_lo(ol), .powerup_hold(hold), .write_busy(busy));
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        i_cpu.get(a, v);
        chk({6'h00, v}, {6'h00, e});
    endtask : rd_chk
    task automatic opts(input logic [4:0] e);
        chk({9'h000, pp, dprot, wd, oh, ol}, {9'h000, e});
    endtask : opts
    task automatic start_write(input logic [7:0] a, input logic [7:0] d);
        i_cpu.put(edg_pkg::OFS_ADDR, a);
        i_cpu.put(edg_pkg::OFS_DATA, d);
        i_cpu.put(edg_pkg::OFS_CTRL, 8'h04);
        i_cpu.unlock();
        @(negedge mclk);
    endtask : start_write
    task automatic results();
        $display("tests %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    // ****************
    // tests
    // ****************
    initial begin
        #100000;
        fails++;
        results();
    end
    initial begin
        repeat (16) @(posedge mclk);
        por <= 1'b0;
        i_cpu.idle();
        rd_chk(edg_pkg::OFS_CTRL, 8'h00);
        prog_mode <= 1'b1;
        prog_addr <= edg_pkg::CFG_ADDR;
        prog_wdata <= 14'h3f43;
        prog_we <= 1'b1;
        @(posedge mclk);
        prog_we <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        chk(prog_rdata, 14'h3f43);
        chk({13'h0000, hold}, 14'h0001);
        @(posedge mclk);
        prog_mode <= 1'b0;
        start_write(8'h01, 8'h11);
        chk({13'h0000, busy}, 14'h0000);
        chk(prog_rdata, 14'h0000);
        @(posedge mclk);
        for (n = 0; n < 100 && hold !== 1'b0; n++) @(posedge mclk);
        chk({13'h0000, hold}, 14'h0000);
        opts(5'b11011);
        prog_wdata <= 14'h0000;
        prog_we <= 1'b1;
        @(posedge mclk);
        prog_we <= 1'b0;
        @(posedge mclk);
        opts(5'b11011);
        chk(prog_rdata, 14'h0000);
        $display("test config done");
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({13'h0000, hold}, 14'h0000);
        rd_chk(edg_pkg::OFS_CTRL, 8'h00);
        i_cpu.put(edg_pkg::OFS_CTRL, 8'h02);
        i_cpu.unlock();
        @(negedge mclk);
        chk({13'h0000, busy}, 14'h0000);
        @(posedge mclk);
        i_cpu.put(edg_pkg::OFS_CTRL, 8'h04);
        i_cpu.put(edg_pkg::OFS_KEY, edg_pkg::KEY_FIRST);
        i_cpu.put(edg_pkg::OFS_DATA, 8'h77);
        i_cpu.put(edg_pkg::OFS_KEY, edg_pkg::KEY_SECOND);
        i_cpu.put(edg_pkg::OFS_CTRL, 8'h06);
        i_cpu.idle();
        @(negedge mclk);
        chk({13'h0000, busy}, 14'h0000);
        $display("test refusals done");
        @(posedge mclk);
        start_write(8'h05, 8'ha5);
        chk({13'h0000, busy}, 14'h0001);
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge mclk);
        @(posedge mclk);
        rd_chk(edg_pkg::OFS_CTRL, 8'h14);
        i_cpu.put(edg_pkg::OFS_CTRL, 8'h04);
        rd_chk(edg_pkg::OFS_CTRL, 8'h04);
        i_cpu.put(edg_pkg::OFS_DATA, 8'h00);
        i_cpu.put(edg_pkg::OFS_CTRL, 8'h05);
        repeat (3) i_cpu.idle();
        rd_chk(edg_pkg::OFS_DATA, 8'ha5);
        opts(5'b11011);
        rd_chk(edg_pkg::OFS_CFG, 8'hc3);
        rd_chk(edg_pkg::OFS_KEY, 8'h00);
        rd_chk(8'h40, 8'h00);
        $display("test write done");
        start_write(8'h06, 8'h3c);
        repeat (10) @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd_chk(edg_pkg::OFS_CTRL, 8'h08);
        rd_chk(edg_pkg::OFS_ADDR, 8'h06);
        rd_chk(edg_pkg::OFS_DATA, 8'h3c);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd_chk(edg_pkg::OFS_CTRL, 8'h08);
        $display("test abort done");
        por <= 1'b1;
        repeat (2) @(posedge mclk);
        por <= 1'b0;
        i_cpu.idle();
        rd_chk(edg_pkg::OFS_CTRL, 8'h00);
        opts(5'b00111);
        chk({13'h0000, hold}, 14'h0000);
        $display("test power-on done");
        results();
    end
endmodule : tb_data_eeprom_guard_and_config_word
`default_nettype wire
